/* File: mgmr_pkg.sv */
// Constants, field layouts and carrier types for the microphone gain and
// listen-through control register bank.
// Assumes a 25 MHz system clock and a 32-bit Avalon-MM register port.
package mgmr_pkg;

    // ********************************************************************
    // Bus geometry
    // ********************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int IDX_W  = 6;
    localparam int REG_W  = 8;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_LEFT_GAIN  = 6'h0B;
    localparam logic [IDX_W-1:0] IDX_RIGHT_GAIN = 6'h0C;
    localparam logic [IDX_W-1:0] IDX_CTRL_A     = 6'h0D;
    localparam logic [IDX_W-1:0] IDX_CTRL_B     = 6'h0E;
    localparam logic [IDX_W-1:0] IDX_ATTEN      = 6'h20;
    localparam logic [IDX_W-1:0] IDX_STATUS     = 6'h21;
    localparam logic [1:0]       BYTE_LANE_ZERO = 2'h0;

    // ********************************************************************
    // Microphone gain fields
    // ********************************************************************
    localparam int             GAIN_W         = 7;
    localparam logic [6:0]     GAIN_RESET     = 7'h57;
    localparam logic [6:0]     GAIN_FORBIDDEN = 7'h3F;
    localparam logic [6:0]     MUTE_CODE_NEG  = 7'h57;
    localparam logic [6:0]     MUTE_CODE_POS  = 7'h7F;
    localparam int             NUM_MICS       = 2;
    localparam int             ATTEN_BIT      = 0;
    localparam logic           ATTEN_RESET    = 1'b0;

    // ********************************************************************
    // Listen-through control fields
    // ********************************************************************
    localparam int         CTRL_A_ENABLE_BIT = 7;
    localparam int         CTRL_A_MUTE_BIT   = 5;
    localparam int         CTRL_A_OPL_BIT    = 1;
    localparam int         CTRL_A_OPR_BIT    = 0;
    localparam logic [7:0] CTRL_A_RESET      = 8'hA0;
    localparam logic [7:0] CTRL_A_MASK       = 8'hA3;
    localparam int         CTRL_B_TIME_LSB   = 4;
    localparam int         CTRL_B_SRC_LSB    = 0;
    localparam int         SEL_W             = 2;
    localparam logic [7:0] CTRL_B_RESET      = 8'h00;
    localparam logic [7:0] CTRL_B_MASK       = 8'h33;
    localparam int         STAT_ACTIVE_BIT   = 0;
    localparam int         STAT_SWITCH_BIT   = 1;

    localparam logic [1:0] SRC_QUAD_MIC = 2'h0;
    localparam logic [1:0] SRC_OPAMP    = 2'h1;
    localparam logic [1:0] SRC_RESERVED = 2'h2;
    localparam logic [1:0] SRC_NONE     = 2'h3;

    // ********************************************************************
    // Timing
    // ********************************************************************
    localparam int CLK_HZ    = 25_000_000;
    localparam int CLK_KHZ   = CLK_HZ / 1000;
    localparam int HOLD_MS_0 = 25;
    localparam int HOLD_MS_1 = 200;
    localparam int HOLD_MS_2 = 400;
    localparam int HOLD_MS_3 = 600;
    localparam int HOLD_CYC_0 = HOLD_MS_0 * CLK_KHZ;
    localparam int HOLD_CYC_1 = HOLD_MS_1 * CLK_KHZ;
    localparam int HOLD_CYC_2 = HOLD_MS_2 * CLK_KHZ;
    localparam int HOLD_CYC_3 = HOLD_MS_3 * CLK_KHZ;
    localparam int HOLD_CNT_W = 24;

    // ********************************************************************
    // Carriers
    // ********************************************************************
    typedef struct packed {
        logic [GAIN_W-1:0] gain;
        logic              mute;
    } mgmr_mic_s;

    typedef struct packed {
        logic active;
        logic line_mute;
        logic opamp_left_on;
        logic opamp_right_on;
        logic route_quad_mic;
        logic route_opamp;
    } mgmr_lt_s;

endpackage : mgmr_pkg

/* File: mgmr_hold_timer.sv */
// Push switch synchroniser and hold-time qualifier.
// Assumes the switch pin is asynchronous and active high while pressed.
module mgmr_hold_timer
    import mgmr_pkg::*;
#(
    parameter int HOLD_CYCLES_0 = HOLD_CYC_0,
    parameter int HOLD_CYCLES_1 = HOLD_CYC_1,
    parameter int HOLD_CYCLES_2 = HOLD_CYC_2,
    parameter int HOLD_CYCLES_3 = HOLD_CYC_3
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    input  wire logic             clk_en,
    // Switch and control
    input  wire logic             switch_pin,
    input  wire logic [SEL_W-1:0] switch_hold_time,
    input  wire logic             arm,
    // Results
    output logic                  pressed,
    output logic                  fire
);

    logic                  sync_a;
    logic                  sync_b;
    logic [HOLD_CNT_W-1:0] cnt;
    logic [HOLD_CNT_W-1:0] next_cnt;
    logic [HOLD_CNT_W-1:0] limit;
    logic                  fired;
    logic                  next_fired;
    logic                  next_fire;

    // ********************************************************************
    // Hold measurement
    // ********************************************************************
    always_comb begin
        case (switch_hold_time)
            2'h0:    limit = HOLD_CNT_W'(HOLD_CYCLES_0 - 1);
            2'h1:    limit = HOLD_CNT_W'(HOLD_CYCLES_1 - 1);
            2'h2:    limit = HOLD_CNT_W'(HOLD_CYCLES_2 - 1);
            default: limit = HOLD_CNT_W'(HOLD_CYCLES_3 - 1);
        endcase
        next_cnt   = cnt;
        next_fired = fired;
        next_fire  = 1'b0;
        // Release restarts the count: only one unbroken press qualifies
        if (!sync_b || !arm) begin
            next_cnt   = '0;
            next_fired = 1'b0;
        end else if (!fired) begin
            if (cnt >= limit) begin
                next_fire  = 1'b1;
                next_fired = 1'b1;
            end else begin
                next_cnt = cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sync_a  <= 1'b0;
            sync_b  <= 1'b0;
            pressed <= 1'b0;
            cnt     <= '0;
            fired   <= 1'b0;
            fire    <= 1'b0;
        end else if (clk_en) begin
            sync_a  <= switch_pin;
            sync_b  <= sync_a;
            pressed <= sync_b;
            cnt     <= next_cnt;
            fired   <= next_fired;
            fire    <= next_fire;
        end
    end

endmodule : mgmr_hold_timer

/* File: mgmr_regs.sv */
// Microphone gain and listen-through mode register bank, Avalon-MM slave.
// Assumes one 25 MHz clock, synchronous reset and a host that keeps to
// the legal field codes.
module mgmr_regs
    import mgmr_pkg::*;
#(
    parameter int HOLD_CYCLES_0 = HOLD_CYC_0,
    parameter int HOLD_CYCLES_1 = HOLD_CYC_1,
    parameter int HOLD_CYCLES_2 = HOLD_CYC_2,
    parameter int HOLD_CYCLES_3 = HOLD_CYC_3
) (
    // Clock, reset and enable
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    input  wire logic              clk_en,
    // Avalon-MM register port
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [DATA_W-1:0] avs_writedata,
    output logic      [DATA_W-1:0] avs_readdata,
    output logic                   avs_waitrequest,
    // Listen-through push switch pin
    input  wire logic              listen_switch,
    // Analog control outputs
    output mgmr_mic_s              left_mic,
    output mgmr_mic_s              right_mic,
    output mgmr_lt_s               listen_through
);

    // ********************************************************************
    // State
    // ********************************************************************
    logic [GAIN_W-1:0] left_mic_gain_cancel;
    logic [GAIN_W-1:0] right_mic_gain_cancel;
    logic [REG_W-1:0]  listen_through_ctrl_a;
    logic [REG_W-1:0]  listen_through_ctrl_b;
    logic              negative_attenuation_enable;
    logic [GAIN_W-1:0] next_left_gain;
    logic [GAIN_W-1:0] next_right_gain;
    logic [REG_W-1:0]  next_ctrl_a;
    logic [REG_W-1:0]  next_ctrl_b;
    logic              next_atten;

    logic [DATA_W-1:0] next_readdata;
    logic              next_waitrequest;
    logic [IDX_W-1:0]  idx;
    logic              aligned;
    logic              request;
    logic              commit_write;

    logic              lt_active;
    logic              next_lt_active;
    mgmr_lt_s          next_lt;
    logic              switch_pressed;
    logic              switch_fire;

    logic [GAIN_W-1:0] mic_gain [NUM_MICS];
    mgmr_mic_s         mic_q    [NUM_MICS];

    // Field views of the control registers
    logic              listen_through_enable;
    logic              listen_through_line_mute;
    logic              listen_through_opamp_left_on;
    logic              listen_through_opamp_right_on;
    logic [SEL_W-1:0]  switch_hold_time;
    logic [SEL_W-1:0]  listen_through_headphone_source;

    assign listen_through_enable =
        listen_through_ctrl_a[CTRL_A_ENABLE_BIT];
    assign listen_through_line_mute =
        listen_through_ctrl_a[CTRL_A_MUTE_BIT];
    assign listen_through_opamp_left_on =
        listen_through_ctrl_a[CTRL_A_OPL_BIT];
    assign listen_through_opamp_right_on =
        listen_through_ctrl_a[CTRL_A_OPR_BIT];
    assign switch_hold_time =
        listen_through_ctrl_b[CTRL_B_TIME_LSB +: SEL_W];
    assign listen_through_headphone_source =
        listen_through_ctrl_b[CTRL_B_SRC_LSB +: SEL_W];

    // ********************************************************************
    // Bus decode
    // ********************************************************************
    assign idx          = avs_address[ADDR_W-1:2];
    assign aligned      = (avs_address[1:0] == BYTE_LANE_ZERO);
    assign request      = avs_read || avs_write;
    // A write lands on the edge where the master sees waitrequest low
    assign commit_write = avs_write && !avs_waitrequest;

    // ********************************************************************
    // Bus handshake and read data
    // ********************************************************************
    // One wait cycle: read data is built in the first cycle so that it
    // already stands when waitrequest falls.
    always_comb begin
        next_waitrequest = 1'b1;
        if (request && avs_waitrequest) begin
            next_waitrequest = 1'b0;
        end
        next_readdata = avs_readdata;
        if (avs_read && avs_waitrequest) begin
            next_readdata = '0;
            if (aligned) begin
                case (idx)
                    IDX_LEFT_GAIN: begin
                        next_readdata[GAIN_W-1:0] = left_mic_gain_cancel;
                    end
                    IDX_RIGHT_GAIN: begin
                        next_readdata[GAIN_W-1:0] = right_mic_gain_cancel;
                    end
                    IDX_CTRL_A: begin
                        next_readdata[REG_W-1:0] = listen_through_ctrl_a;
                    end
                    IDX_CTRL_B: begin
                        next_readdata[REG_W-1:0] = listen_through_ctrl_b;
                    end
                    IDX_ATTEN: begin
                        next_readdata[ATTEN_BIT] =
                            negative_attenuation_enable;
                    end
                    IDX_STATUS: begin
                        next_readdata[STAT_ACTIVE_BIT] = lt_active;
                        next_readdata[STAT_SWITCH_BIT] = switch_pressed;
                    end
                    default: begin
                        next_readdata = '0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= '0;
        end else if (clk_en) begin
            avs_waitrequest <= next_waitrequest;
            avs_readdata    <= next_readdata;
        end
    end

    // ********************************************************************
    // Register writes
    // ********************************************************************
    // Unmapped or misaligned writes are acknowledged and dropped. Forbidden
    // codes are stored as written; keeping to legal codes is the host's job.
    always_comb begin
        next_left_gain  = left_mic_gain_cancel;
        next_right_gain = right_mic_gain_cancel;
        next_ctrl_a     = listen_through_ctrl_a;
        next_ctrl_b     = listen_through_ctrl_b;
        next_atten      = negative_attenuation_enable;
        if (commit_write && aligned) begin
            case (idx)
                IDX_LEFT_GAIN: begin
                    next_left_gain = avs_writedata[GAIN_W-1:0];
                end
                IDX_RIGHT_GAIN: begin
                    next_right_gain = avs_writedata[GAIN_W-1:0];
                end
                IDX_CTRL_A: begin
                    next_ctrl_a = avs_writedata[REG_W-1:0] & CTRL_A_MASK;
                end
                IDX_CTRL_B: begin
                    next_ctrl_b = avs_writedata[REG_W-1:0] & CTRL_B_MASK;
                end
                IDX_ATTEN: begin
                    next_atten = avs_writedata[ATTEN_BIT];
                end
                default: begin
                    next_atten = negative_attenuation_enable;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            left_mic_gain_cancel        <= GAIN_RESET;
            right_mic_gain_cancel       <= GAIN_RESET;
            listen_through_ctrl_a       <= CTRL_A_RESET;
            listen_through_ctrl_b       <= CTRL_B_RESET;
            negative_attenuation_enable <= ATTEN_RESET;
        end else if (clk_en) begin
            left_mic_gain_cancel        <= next_left_gain;
            right_mic_gain_cancel       <= next_right_gain;
            listen_through_ctrl_a       <= next_ctrl_a;
            listen_through_ctrl_b       <= next_ctrl_b;
            negative_attenuation_enable <= next_atten;
        end
    end

    // ********************************************************************
    // Microphone gain outputs
    // ********************************************************************
    assign mic_gain[0] = left_mic_gain_cancel;
    assign mic_gain[1] = right_mic_gain_cancel;

    // Gain code passes through as a half-dB count; the mute code depends
    // on the attenuation mode, and the other mute code is then an
    // ordinary (unused) code.
    for (genvar ch = 0; ch < NUM_MICS; ch++) begin : g_mic
        mgmr_mic_s next_mic;

        always_comb begin
            next_mic.gain = mic_gain[ch];
            if (negative_attenuation_enable) begin
                next_mic.mute = (mic_gain[ch] == MUTE_CODE_NEG);
            end else begin
                next_mic.mute = (mic_gain[ch] == MUTE_CODE_POS);
            end
        end

        always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
                mic_q[ch] <= '{gain: GAIN_RESET, mute: 1'b0};
            end else if (clk_en) begin
                mic_q[ch] <= next_mic;
            end
        end
    end

    assign left_mic  = mic_q[0];
    assign right_mic = mic_q[1];

    // ********************************************************************
    // Push switch hold timer
    // ********************************************************************
    mgmr_hold_timer #(
        .HOLD_CYCLES_0 (HOLD_CYCLES_0),
        .HOLD_CYCLES_1 (HOLD_CYCLES_1),
        .HOLD_CYCLES_2 (HOLD_CYCLES_2),
        .HOLD_CYCLES_3 (HOLD_CYCLES_3)
    ) u_hold (
        .sys_clk          (sys_clk),
        .sys_rst          (sys_rst),
        .clk_en           (clk_en),
        .switch_pin       (listen_switch),
        .switch_hold_time (switch_hold_time),
        .arm              (listen_through_enable),
        .pressed          (switch_pressed),
        .fire             (switch_fire)
    );

    // ********************************************************************
    // Listen-through mode and its outputs
    // ********************************************************************
    // Each qualified press toggles the mode; a new press needs a release
    // first, so holding the switch never makes it flicker.
    always_comb begin
        next_lt_active = lt_active;
        if (!listen_through_enable) begin
            next_lt_active = 1'b0;
        end else if (switch_fire) begin
            next_lt_active = !lt_active;
        end
        next_lt.active         = next_lt_active;
        next_lt.line_mute      = next_lt_active &&
                                 listen_through_line_mute;
        next_lt.opamp_left_on  = next_lt_active &&
                                 listen_through_opamp_left_on;
        next_lt.opamp_right_on = next_lt_active &&
                                 listen_through_opamp_right_on;
        next_lt.route_quad_mic = 1'b0;
        next_lt.route_opamp    = 1'b0;
        case (listen_through_headphone_source)
            SRC_QUAD_MIC: begin
                next_lt.route_quad_mic = next_lt_active;
            end
            SRC_OPAMP: begin
                next_lt.route_opamp = next_lt_active;
            end
            SRC_RESERVED: begin
                // Reserved path is absent here, so it drives nothing
                next_lt.route_opamp = 1'b0;
            end
            default: begin
                next_lt.route_quad_mic = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            lt_active      <= 1'b0;
            listen_through <= '0;
        end else if (clk_en) begin
            lt_active      <= next_lt_active;
            listen_through <= next_lt;
        end
    end

endmodule : mgmr_regs

/* File: mgmr_regs_chk.sv */
// Port checker for the gain and listen-through register bank.
// Assumes clk_en stays high; the bind hands on the hold counts.
module mgmr_regs_chk
    import mgmr_pkg::*;
#(
    parameter int HOLD_CYCLES_0 = HOLD_CYC_0,
    parameter int HOLD_CYCLES_1 = HOLD_CYC_1,
    parameter int HOLD_CYCLES_2 = HOLD_CYC_2,
    parameter int HOLD_CYCLES_3 = HOLD_CYC_3
) (
    // Clock and reset
    input wire logic              sys_clk,
    input wire logic              sys_rst,
    input wire logic              clk_en,
    // Register port
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic              avs_read,
    input wire logic              avs_write,
    input wire logic [DATA_W-1:0] avs_writedata,
    input wire logic [DATA_W-1:0] avs_readdata,
    input wire logic              avs_waitrequest,
    // Pin and controls
    input wire logic              listen_switch,
    input wire mgmr_mic_s         left_mic,
    input wire mgmr_mic_s         right_mic,
    input wire mgmr_lt_s          listen_through
);
    localparam int HT[4] = '{HOLD_CYCLES_0, HOLD_CYCLES_1,
                             HOLD_CYCLES_2, HOLD_CYCLES_3};
    logic [6:0]  l_sh;
    logic [6:0]  r_sh;
    logic [7:0]  a_sh;
    logic [7:0]  b_sh;
    logic        at_sh;
    logic [23:0] run;
    logic        wr_done;
    // ********
    // Shadows follow each completed write
    // ********
    assign wr_done = avs_write && !avs_waitrequest;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            l_sh  <= GAIN_RESET;
            r_sh  <= GAIN_RESET;
            a_sh  <= CTRL_A_RESET;
            b_sh  <= CTRL_B_RESET;
            at_sh <= ATTEN_RESET;
        end else if (wr_done) begin
            if (avs_address == 8'h2C) l_sh <= avs_writedata[6:0];
            if (avs_address == 8'h30) r_sh <= avs_writedata[6:0];
            if (avs_address == 8'h34) a_sh <= avs_writedata[7:0];
            if (avs_address == 8'h38) b_sh <= avs_writedata[7:0];
            if (avs_address == 8'h80) at_sh <= avs_writedata[0];
        end
    end
    // Raw pin run length; the sync delay sits inside the slack
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !listen_switch) run <= '0;
        else run <= run + 24'h1;
    end
    // ********
    // Properties
    // ********
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    chk_gain_out:
        assert property (left_mic.gain == $past(l_sh)
            && right_mic.gain == $past(r_sh))
        else $error("gain output wrong");
    chk_mute_neg:
        assert property ($past(at_sh) |->
            left_mic.mute == (left_mic.gain == MUTE_CODE_NEG)
            && right_mic.mute == (right_mic.gain == MUTE_CODE_NEG))
        else $error("mute wrong with attenuation set");
    chk_mute_pos:
        assert property (!$past(at_sh) |->
            left_mic.mute == (left_mic.gain == MUTE_CODE_POS)
            && right_mic.mute == (right_mic.gain == MUTE_CODE_POS))
        else $error("mute wrong with attenuation clear");
    chk_lt_off:
        assert property (!a_sh[7] && !$past(a_sh[7])
            |-> !listen_through.active)
        else $error("active while disabled");
    chk_line_mute:
        assert property (listen_through.line_mute
            == (listen_through.active && $past(a_sh[5])))
        else $error("line mute wrong");
    chk_opamps:
        assert property ({listen_through.opamp_left_on,
            listen_through.opamp_right_on} == ({2{listen_through.active}}
            & $past(a_sh[1:0])))
        else $error("op-amp enables wrong");
    chk_route_sel:
        assert property (listen_through.route_quad_mic
            == (listen_through.active && $past(b_sh[1:0]) == SRC_QUAD_MIC)
            && listen_through.route_opamp
            == (listen_through.active && $past(b_sh[1:0]) == SRC_OPAMP))
        else $error("source routing wrong");
    chk_unmapped:
        assert property (avs_read && !avs_waitrequest && avs_address == 8'hFC
            |-> avs_readdata == '0)
        else $error("unmapped read not zero");
    chk_hold_time:
        assert property ($rose(listen_through.active) |->
            int'(run) >= HT[b_sh[5:4]] && int'(run) <= HT[b_sh[5:4]] + 12)
        else $error("toggle without a full press");
endmodule : mgmr_regs_chk

/* File: mgmr_sw_model.sv */
// Push switch model for the listen-through button.
// Assumes a pull-down holds the pin low while released.
module mgmr_sw_model (
    // Clock and pin
    input  wire logic sys_clk,
    output logic      listen_switch
);
    timeunit 1ns;
    timeprecision 1ns;
    initial listen_switch = 1'b0;
    task automatic press(input int n);
        @(posedge sys_clk);
        listen_switch <= 1'b1;
        repeat (n) @(posedge sys_clk);
        listen_switch <= 1'b0;
    endtask : press
endmodule : mgmr_sw_model

/* File: mgmr_regs_tb.sv */
// Self-checking bench for the gain and listen-through register bank.
// Assumes short hold counts and the switch model as the far side.
module mgmr_regs_tb
    import mgmr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HT[4] = '{20, 40, 60, 80};
    logic              sys_clk, sys_rst, clk_en, avs_read, avs_write;
    logic [ADDR_W-1:0] avs_address;
    logic [DATA_W-1:0] avs_writedata, avs_readdata, d;
    logic              avs_waitrequest, listen_switch, at, act;
    mgmr_mic_s         left_mic, right_mic;
    mgmr_lt_s          listen_through;
    logic [6:0]        lg, rg;
    logic [7:0]        ca, cb;
    logic [31:0]       expq[$];
    int                errors = 0, compares = 0, seed = 32'h3F11;
    mgmr_regs #(.HOLD_CYCLES_0(20), .HOLD_CYCLES_1(40),
        .HOLD_CYCLES_2(60), .HOLD_CYCLES_3(80)) dut_u (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .listen_switch(listen_switch), .left_mic(left_mic),
        .right_mic(right_mic), .listen_through(listen_through));
    mgmr_sw_model sw_u (.sys_clk(sys_clk), .listen_switch(listen_switch));
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [31:0] got, exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    // Reads note v as the expected data; writes update the model
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] v);
        if (!w) expq.push_back(v);
        @(posedge sys_clk);
        avs_address   <= a;
        avs_writedata <= v;
        avs_write     <= w;
        avs_read      <= !w;
        do @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        if (w) begin
            case (a)
                8'h2C: lg = v[6:0];
                8'h30: rg = v[6:0];
                8'h34: ca = v[7:0] & CTRL_A_MASK;
                8'h38: cb = v[7:0] & CTRL_B_MASK;
                8'h80: at = v[0];
                default: ;
            endcase
        end
        if (!ca[7]) act = 1'b0;
    endtask : bus
    task automatic outs();
        logic [5:0] e;
        repeat (4) @(posedge sys_clk);
        e = {act, act & ca[5], act & ca[1], act & ca[0],
             act & (cb[1:0] == 2'h0), act & (cb[1:0] == 2'h1)};
        check({10'h0, left_mic, right_mic, listen_through},
              {10'h0, lg, (at ? lg == 7'h57 : lg == 7'h7F),
               rg, (at ? rg == 7'h57 : rg == 7'h7F), e});
    endtask : outs
    always @(posedge sys_clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
            check(avs_readdata, expq.pop_front());
    end
    task automatic summarize();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        summarize();
    end
    // ********
    // Scenarios
    // ********
    initial begin
        {sys_rst, clk_en} = 2'b11;
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        {lg, rg, ca, cb, at, act} = {7'h57, 7'h57, 8'hA0, 8'h00, 2'b00};
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        bus(1'b0, 8'h2C, 32'h57);
        bus(1'b0, 8'h30, 32'h57);
        bus(1'b0, 8'h34, 32'hA0);
        bus(1'b0, 8'h38, 32'h00);
        bus(1'b0, 8'hFC, 32'h00);
        bus(1'b0, 8'h2D, 32'h00);
        outs();
        bus(1'b1, 8'h34, 32'hFFFF_FFFF);
        bus(1'b0, 8'h34, 32'hA3);
        bus(1'b1, 8'h38, 32'hFFFF_FFFF);
        bus(1'b0, 8'h38, 32'h33);
        $display("reset and mask test done");
        for (int i = 0; i < 16; i++) begin
            d = $random(seed);
            if (d[6:0] == GAIN_FORBIDDEN) d[6:0] = 7'h3E;
            bus(1'b1, i[0] ? 8'h2C : 8'h30, d);
            bus(1'b0, i[0] ? 8'h2C : 8'h30, {25'h0, d[6:0]});
            outs();
        end
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, 8'h80, {31'h0, i[1]});
            d = i[0] ? 32'h7F : 32'h57;
            bus(1'b1, 8'h2C, d);
            bus(1'b1, 8'h30, d);
            outs();
        end
        $display("gain and mute test done");
        for (int s = 0; s < 4; s++) begin
            d = $random(seed);
            bus(1'b1, 8'h34, (d & 32'h23) | 32'h80);
            d = {26'h0, s[1:0], 2'h0, (s == 2) ? 2'h3 : s[1:0]};
            bus(1'b1, 8'h38, d);
            sw_u.press(HT[s] * 2 / 3);
            sw_u.press(HT[s] * 2 / 3);
            outs();
            sw_u.press(HT[s] + 16);
            act = ~act;
            outs();
        end
        sw_u.press(HT[3] + 16);
        act = 1'b1;
        outs();
        bus(1'b0, 8'h84, 32'h01);
        clk_en <= 1'b0;
        sw_u.press(HT[3] + 16);
        clk_en <= 1'b1;
        outs();
        bus(1'b1, 8'h34, 32'h23);
        outs();
        sw_u.press(HT[3] + 16);
        outs();
        $display("listen-through test done");
        summarize();
    end
endmodule : mgmr_regs_tb
bind mgmr_regs mgmr_regs_chk #(.HOLD_CYCLES_0(HOLD_CYCLES_0),
    .HOLD_CYCLES_1(HOLD_CYCLES_1), .HOLD_CYCLES_2(HOLD_CYCLES_2),
    .HOLD_CYCLES_3(HOLD_CYCLES_3)) chk_u (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .listen_switch(listen_switch), .left_mic(left_mic),
    .right_mic(right_mic), .listen_through(listen_through));
